// ### verilog/apbc_pkg.sv
// Constants, types and register map of the ATA power and buffer command block
//
// Operation
// RQ1 - Sleep opcodes set busy, enter sleep, clear busy, raise interrupt.
// RQ2 - Any further command written by the host wakes the device.
// RQ3 - Inactivity timer of 5 ms puts the device to sleep by itself.
// RQ4 - Standby opcodes set busy, enter sleep, clear busy, interrupt at once.
// RQ5 - Standby-immediate opcodes behave the same way, interrupting at once.
// RQ6 - Translate-sector returns a 512-byte information block for the addressed sector.
// RQ7 - Block bytes 0..3 hold cylinder high, cylinder low, head, sector.
// RQ8 - Bytes 4..6 hold the sector's logical address, most significant first.
// RQ9 - Byte 13h reads FFh when erased, 00h when not.
// RQ10 - Bytes 18h..1Ah hold program/erase count, MSB first; zero means unsupported.
// RQ11 - Wear-level opcode is a no-op returning zero in sector count.
// RQ12 - Write-buffer takes exactly 512 bytes and replaces the sector buffer.
// RQ13 - Sector-write handshake: busy, then data request with busy cleared.
// RQ14 - Logical address from cylinder high, cylinder low, sector number, head.
// RQ15 - Reserved bytes of the information block read as zero.
// RQ16 - Information block delivered by PIO read: busy clears, request sets, interrupt.
package apbc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_DATA = 4'h0;
  localparam logic [3:0] IDX_FEATURE = 4'h1;
  localparam logic [3:0] IDX_SECT_CNT = 4'h2;
  localparam logic [3:0] IDX_SECT_NUM = 4'h3;
  localparam logic [3:0] IDX_CYL_LO = 4'h4;
  localparam logic [3:0] IDX_CYL_HI = 4'h5;
  localparam logic [3:0] IDX_DRV_HEAD = 4'h6;
  localparam logic [3:0] IDX_COMMAND = 4'h7;
  localparam logic [3:0] IDX_IRQ_STAT = 4'h8;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h9;
  localparam logic [3:0] IDX_POWER = 4'hA;
  localparam logic [3:0] IDX_LAST = 4'hA;

  // Status byte read at the command index
  localparam int SB_BSY = 7;
  localparam int SB_RDY = 6;
  localparam int SB_DRQ = 3;
  localparam int SB_ERR = 0;

  // Interrupt status and mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_DRQ = 1;
  localparam int IRQ_SLEEP = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  // Opcodes
  localparam logic [7:0] OP_SLEEP_A = 8'h99;
  localparam logic [7:0] OP_SLEEP_B = 8'hE6;
  localparam logic [7:0] OP_STBY_A = 8'h96;
  localparam logic [7:0] OP_STBY_B = 8'hE2;
  localparam logic [7:0] OP_STBYI_A = 8'h94;
  localparam logic [7:0] OP_STBYI_B = 8'hE0;
  localparam logic [7:0] OP_TRANSLATE = 8'h87;
  localparam logic [7:0] OP_WEAR = 8'hF5;
  localparam logic [7:0] OP_WRITE_BUF = 8'hE8;
  localparam logic [7:0] WEAR_NOT_NEEDED = 8'h00;

  // Information block layout
  localparam int BUF_BYTES = 512;
  localparam int BUF_AW = 9;
  localparam logic [8:0] INFO_CYL_HI = 9'h000;
  localparam logic [8:0] INFO_CYL_LO = 9'h001;
  localparam logic [8:0] INFO_HEAD = 9'h002;
  localparam logic [8:0] INFO_SECT = 9'h003;
  localparam logic [8:0] INFO_LBA_HI = 9'h004;
  localparam logic [8:0] INFO_LBA_MID = 9'h005;
  localparam logic [8:0] INFO_LBA_LO = 9'h006;
  localparam logic [8:0] INFO_ERASED = 9'h013;
  localparam logic [8:0] INFO_HOT_HI = 9'h018;
  localparam logic [8:0] INFO_HOT_MID = 9'h019;
  localparam logic [8:0] INFO_HOT_LO = 9'h01A;
  localparam logic [7:0] ERASED_YES = 8'hFF;
  localparam logic [7:0] ERASED_NO = 8'h00;

  // Inactivity timer
  localparam int CLK_PERIOD_NS = 100;
  localparam int SLEEP_TIME_NS = 5000000;
  localparam int SLEEP_CYCLES = SLEEP_TIME_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] sect_cnt;
    logic [7:0] sect_num;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] drv_head;
  } apbc_taskfile_s;

  localparam apbc_taskfile_s TF_RESET = '0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_FILL = 3'b010,
    ST_XFER_OUT = 3'b011,
    ST_XFER_IN = 3'b100,
    ST_FINISH = 3'b101
  } apbc_state_e;

endpackage

// ### verilog/apbc_sector_mem.sv
// Sector buffer: simple dual-port byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module apbc_sector_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 512,
  parameter int unsigned AW = 9
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  if (DEPTH > (1 << AW) || DEPTH < 2) begin : g_bad_depth
    $error("apbc_sector_mem: DEPTH does not fit AW");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  // No reset on the array; read data is only used once a transfer is set up
  always_ff @(posedge clk) begin
    rdata <= mem_q[raddr];
  end

endmodule
`default_nettype wire

// ### verilog/apbc_top.sv
// ATA power and buffer command block behind an APB register slave
`timescale 1ns/1ps
`default_nettype none
module apbc_top
  import apbc_pkg::*;
#(
  parameter int unsigned SLEEP_CNT = SLEEP_CYCLES,
  parameter int unsigned BUF_DEPTH = BUF_BYTES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic sleep_mode,
  input wire logic media_erased,
  input wire logic [23:0] media_hot_count
);

  if (BUF_DEPTH != BUF_BYTES) begin : g_bad_buf
    $error("apbc_top: information block layout needs a 512-byte buffer");
  end
  if (SLEEP_CNT < 2) begin : g_bad_sleep
    $error("apbc_top: SLEEP_CNT must be at least 2");
  end

  localparam logic [BUF_AW-1:0] LAST_BYTE = BUF_AW'(BUF_DEPTH - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [27:0] lba_of(input apbc_taskfile_s tf);
    // RQ14 address assembly
    lba_of = {tf.drv_head[3:0], tf.cyl_hi, tf.cyl_lo, tf.sect_num};
  endfunction

  function automatic logic is_sleep_op(input logic [7:0] op);
    is_sleep_op = (op == OP_SLEEP_A) || (op == OP_SLEEP_B) || (op == OP_STBY_A) ||
                  (op == OP_STBY_B) || (op == OP_STBYI_A) || (op == OP_STBYI_B);
  endfunction

  function automatic logic [7:0] info_byte(
    input logic [BUF_AW-1:0] a,
    input apbc_taskfile_s tf,
    input logic erased,
    input logic [23:0] hot
  );
    logic [27:0] lba;
    lba = lba_of(tf);
    case (a)
      // RQ7 cylinder head sector
      INFO_CYL_HI: info_byte = tf.cyl_hi;
      INFO_CYL_LO: info_byte = tf.cyl_lo;
      INFO_HEAD: info_byte = {4'h0, tf.drv_head[3:0]};
      INFO_SECT: info_byte = tf.sect_num;
      // RQ8 address MSB first
      INFO_LBA_HI: info_byte = lba[23:16];
      INFO_LBA_MID: info_byte = lba[15:8];
      INFO_LBA_LO: info_byte = lba[7:0];
      // RQ9 erased flag
      INFO_ERASED: info_byte = erased ? ERASED_YES : ERASED_NO;
      // RQ10 program/erase count
      INFO_HOT_HI: info_byte = hot[23:16];
      INFO_HOT_MID: info_byte = hot[15:8];
      INFO_HOT_LO: info_byte = hot[7:0];
      // RQ15 reserved bytes zero
      default: info_byte = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  apbc_state_e state_q;
  apbc_state_e state_d;
  apbc_taskfile_s tf_q;
  logic [7:0] opcode_q;
  logic err_q;
  logic sleep_q;
  logic erased_q;
  logic [23:0] hot_q;
  logic [31:0] tmr_q;
  logic [BUF_AW-1:0] byte_q;
  logic [BUF_AW-1:0] byte_d;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_stat_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic [7:0] mem_rdata;
  logic [3:0] ridx;
  logic mapped;
  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic idle;
  logic busy;
  logic drq;
  logic cmd_wr;
  logic tf_wr;
  logic data_rd;
  logic data_wr;
  logic fill;
  logic mem_we;
  logic [7:0] mem_wdata;
  logic tmr_expire;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign ridx = paddr[5:2];
  assign mapped = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) && (ridx <= IDX_LAST);
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready_q && pwrite && mapped;
  assign rd_acc = psel && penable && pready_q && !pwrite && mapped;
  assign idle = (state_q == ST_IDLE);
  // RQ13 busy and request flags
  assign busy = (state_q == ST_CMD) || (state_q == ST_FILL) || (state_q == ST_FINISH);
  assign drq = (state_q == ST_XFER_IN) || (state_q == ST_XFER_OUT);
  // Task file is frozen while a command runs, as on a real drive
  assign tf_wr = wr_acc && idle;
  assign cmd_wr = tf_wr && (ridx == IDX_COMMAND);
  assign data_rd = rd_acc && (ridx == IDX_DATA) && (state_q == ST_XFER_OUT);
  // RQ13 data accepted only with request set
  assign data_wr = wr_acc && (ridx == IDX_DATA) && (state_q == ST_XFER_IN);
  assign fill = (state_q == ST_FILL);

  function automatic logic [31:0] read_mux(
    input logic [3:0] i,
    input apbc_taskfile_s tf,
    input logic [7:0] status,
    input logic [7:0] dbyte
  );
    unique case (i)
      IDX_DATA: read_mux = {24'h000000, dbyte};
      IDX_FEATURE: read_mux = {24'h000000, tf.feature};
      IDX_SECT_CNT: read_mux = {24'h000000, tf.sect_cnt};
      IDX_SECT_NUM: read_mux = {24'h000000, tf.sect_num};
      IDX_CYL_LO: read_mux = {24'h000000, tf.cyl_lo};
      IDX_CYL_HI: read_mux = {24'h000000, tf.cyl_hi};
      IDX_DRV_HEAD: read_mux = {24'h000000, tf.drv_head};
      IDX_COMMAND: read_mux = {24'h000000, status};
      IDX_IRQ_STAT: read_mux = {29'h00000000, irq_stat_q};
      IDX_IRQ_MASK: read_mux = {29'h00000000, irq_mask_q};
      IDX_POWER: read_mux = {31'h00000000, sleep_q};
      default: read_mux = 32'h00000000;
    endcase
  endfunction

  logic [7:0] status_byte;
  always_comb begin
    status_byte = 8'h00;
    status_byte[SB_BSY] = busy;
    status_byte[SB_RDY] = !busy;
    status_byte[SB_DRQ] = drq;
    status_byte[SB_ERR] = err_q;
  end

  // Zero-wait slave: answer prepared in setup, one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      if (setup) begin
        prdata_q <= (mapped && !pwrite) ? read_mux(ridx, tf_q, status_byte,
                                                    (state_q == ST_XFER_OUT) ? mem_rdata : 8'h00) : 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Task file and command capture

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tf_q <= TF_RESET;
      opcode_q <= 8'h00;
    end else if (tf_wr) begin
      unique case (ridx)
        IDX_FEATURE: tf_q.feature <= pwdata[7:0];
        IDX_SECT_CNT: tf_q.sect_cnt <= pwdata[7:0];
        IDX_SECT_NUM: tf_q.sect_num <= pwdata[7:0];
        IDX_CYL_LO: tf_q.cyl_lo <= pwdata[7:0];
        IDX_CYL_HI: tf_q.cyl_hi <= pwdata[7:0];
        IDX_DRV_HEAD: tf_q.drv_head <= pwdata[7:0];
        IDX_COMMAND: opcode_q <= pwdata[7:0];
        default: ;
      endcase
    end else if (state_q == ST_CMD && opcode_q == OP_WEAR) begin
      // RQ11 wear level not needed
      tf_q.sect_cnt <= WEAR_NOT_NEEDED;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erased_q <= 1'b0;
      hot_q <= 24'h000000;
    end else if (state_q == ST_CMD) begin
      erased_q <= media_erased;
      hot_q <= media_hot_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (cmd_wr) begin
          state_d = ST_CMD;
        end
      end
      ST_CMD: begin
        if (opcode_q == OP_TRANSLATE) begin
          // RQ6 build information block
          state_d = ST_FILL;
        end else if (opcode_q == OP_WRITE_BUF) begin
          // RQ13 request set, busy cleared
          state_d = ST_XFER_IN;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_FILL: begin
        if (byte_q == LAST_BYTE) begin
          // RQ16 hand block to host
          state_d = ST_XFER_OUT;
        end
      end
      ST_XFER_OUT: begin
        if (data_rd && byte_q == LAST_BYTE) begin
          state_d = ST_IDLE;
        end
      end
      ST_XFER_IN: begin
        // RQ12 exactly 512 bytes
        if (data_wr && byte_q == LAST_BYTE) begin
          state_d = ST_FINISH;
        end
      end
      ST_FINISH: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Unknown opcodes abort; flag holds until the next command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 1'b0;
    end else if (cmd_wr) begin
      err_q <= 1'b0;
    end else if (state_q == ST_CMD && !is_sleep_op(opcode_q) && opcode_q != OP_TRANSLATE &&
                 opcode_q != OP_WEAR && opcode_q != OP_WRITE_BUF) begin
      err_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte pointer and sector buffer

  // Next value drives the read port so data is ready for a back-to-back read
  always_comb begin
    byte_d = byte_q;
    if (state_q == ST_CMD) begin
      byte_d = '0;
    end else if (fill || data_rd || data_wr) begin
      byte_d = byte_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_q <= '0;
    end else begin
      byte_q <= byte_d;
    end
  end

  // RQ12 host data replaces buffer
  assign mem_we = fill || data_wr;
  assign mem_wdata = fill ? info_byte(byte_q, tf_q, erased_q, hot_q) : pwdata[7:0];

  apbc_sector_mem #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH),
    .AW(BUF_AW)
  ) u_buf (
    .clk(pclk),
    .we(mem_we),
    .waddr(byte_q),
    .wdata(mem_wdata),
    .raddr(byte_d),
    .rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Power state

  // Any bus access counts as activity
  assign tmr_expire = idle && !sleep_q && !psel && (tmr_q == SLEEP_CNT - 1);

  // RQ3 inactivity timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q <= 32'h00000000;
    end else if (!idle || sleep_q || psel || tmr_expire) begin
      tmr_q <= 32'h00000000;
    end else begin
      tmr_q <= tmr_q + 32'h00000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q <= 1'b0;
    end else if (cmd_wr) begin
      // RQ2 wake on new command
      sleep_q <= 1'b0;
    end else if (state_q == ST_CMD && is_sleep_op(opcode_q)) begin
      // RQ1 RQ4 RQ5 enter sleep
      sleep_q <= 1'b1;
    end else if (tmr_expire) begin
      sleep_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  always_comb begin
    irq_ev = '0;
    // RQ1 RQ4 RQ5 completion interrupt
    irq_ev[IRQ_DONE] = (state_q == ST_CMD && state_d == ST_IDLE) || (state_q == ST_FINISH);
    // RQ16 interrupt before host reads
    irq_ev[IRQ_DRQ] = (state_q == ST_FILL && state_d == ST_XFER_OUT);
    irq_ev[IRQ_SLEEP] = tmr_expire;
  end

  // Set wins over a simultaneous write-one-to-clear
  assign irq_stat_d = (irq_stat_q & ~((wr_acc && ridx == IDX_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0)) | irq_ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
      irq_mask_q <= IRQ_MASK_RESET;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (wr_acc && ridx == IDX_IRQ_MASK) begin
        irq_mask_q <= pwdata[IRQ_W-1:0];
      end
      irq_q <= |(irq_stat_d & ((wr_acc && ridx == IDX_IRQ_MASK) ? pwdata[IRQ_W-1:0] : irq_mask_q));
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign sleep_mode = sleep_q;

endmodule
`default_nettype wire

// ### verif/apbc_host.sv
// Host controller model: APB master and status polling
`timescale 1ns/1ps
`default_nettype none
module apbc_host
  import apbc_pkg::*;
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int hangs = 0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  ////////////////////////////////////////
  // Entered just after a rising edge; idles one cycle after release
  task automatic xfer(input logic w, input logic [3:0] i, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {6'h00, i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50) hangs++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  ////////////////////////////////////////
  // wait until busy and request bits match want
  task automatic wait_status(input logic [7:0] want, output logic [7:0] st);
    logic [31:0] rd;
    logic e;
    int n;
    for (n = 0; n < 1200; n++) begin
      xfer(1'b0, IDX_COMMAND, 32'h0, rd, e);
      st = rd[7:0];
      if ((st & 8'h88) === want) break;
    end
    if (n == 1200) hangs++;
  endtask
endmodule
`default_nettype wire

// ### verif/apbc_checker.sv
// Port-level assertions for the command block
`timescale 1ns/1ps
`default_nettype none
module apbc_checker
  import apbc_pkg::*;
#(
  parameter int unsigned SLEEP_CNT = SLEEP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic sleep_mode,
  input wire logic media_erased,
  input wire logic [23:0] media_hot_count
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic cmd_wr = psel && penable && pready && pwrite && paddr[5:2] == IDX_COMMAND;
  wire logic slp_op = pwdata[7:0] inside {OP_SLEEP_A, OP_SLEEP_B, OP_STBY_A, OP_STBY_B, OP_STBYI_A, OP_STBYI_B};
  logic [2:0] since_q;
  int unsigned quiet_q;
  ////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_q <= 3'h7;
    else if (cmd_wr && slp_op) since_q <= 3'h0;
    else if (since_q != 3'h7) since_q <= since_q + 3'h1;
  end
  // Saturates so a long idle cannot wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_q <= 0;
    else if (psel) quiet_q <= 0;
    else if (quiet_q < SLEEP_CNT + 4) quiet_q <= quiet_q + 1;
  end
  ////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_enter;
    !sleep_mode ##[1:3] sleep_mode;
  endsequence
  a_ready_zero_wait: assert property (s_setup |=> pready && penable) else $error("pready late");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("pready outside access");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
  a_err_unmapped: assert property (pready |-> pslverr == (paddr[5:2] > IDX_LAST)) else $error("pslverr wrong");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("bad read data");
  a_sleep_cmd_enter:
    assert property (cmd_wr && slp_op |=> s_enter) else $error("no sleep after command");
  a_wake_on_cmd:
    assert property (cmd_wr && !slp_op |=> !sleep_mode [*2]) else $error("still asleep");
  a_sleep_has_cause:
    assert property ($rose(sleep_mode) |-> since_q <= 3 || quiet_q + 2 >= SLEEP_CNT) else $error("sleep no cause");
endmodule
bind apbc_top apbc_checker #(.SLEEP_CNT(SLEEP_CNT)) apbc_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .sleep_mode(sleep_mode), .media_erased(media_erased), .media_hot_count(media_hot_count));
`default_nettype wire

// ### verif/apbc_top_bench.sv
// Self-checking bench for the command block
`timescale 1ns/1ps
`default_nettype none
module apbc_top_bench
  import apbc_pkg::*;
;
  localparam int SLP = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic media_erased = 1'b0;
  logic [23:0] media_hot_count = 24'h0;
  wire logic psel, penable, pwrite, pready, pslverr, irq, sleep_mode;
  wire logic [11:0] paddr;
  wire logic [31:0] pwdata, prdata;
  int failures = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic err;
  logic [7:0] st;
  logic [7:0] tf [1:6];
  logic [7:0] blk [$];
  logic [7:0] wq [$];
  logic [7:0] ops [6] = '{OP_SLEEP_A, OP_SLEEP_B, OP_STBY_A, OP_STBY_B, OP_STBYI_A, OP_STBYI_B};
  apbc_top #(.SLEEP_CNT(SLP)) apbc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .sleep_mode(sleep_mode),
    .media_erased(media_erased), .media_hot_count(media_hot_count));
  apbc_host apbc_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial forever #50 pclk = ~pclk;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Registered flags need two edges to settle
  task automatic flg(input string nm, input bit s, input logic e);
    repeat (2) @(negedge pclk);
    chk(nm, {31'h0, e}, {31'h0, s ? sleep_mode : irq});
    @(posedge pclk);
  endtask
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    apbc_host_i.xfer(1'b1, i, d, rd, err);
  endtask
  task automatic rdc(input string nm, input logic [3:0] i, input logic [31:0] e);
    apbc_host_i.xfer(1'b0, i, 32'h0, rd, err);
    chk(nm, e, rd);
  endtask
  task automatic end_of_test;
    failures += apbc_host_i.hangs;
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // A stuck host wait ends the run as well
  initial begin
    for (int c = 0; c < 100000 && apbc_host_i.hangs == 0; c++) @(posedge pclk);
    failures++;
    end_of_test();
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'hD5FF));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 1; i <= 6; i++) begin
      rdc("tf_reset", 4'(i), 32'h0);
      tf[i] = 8'($urandom);
      wr(4'(i), {24'h0, tf[i]});
      rdc("tf_rw", 4'(i), {24'h0, tf[i]});
    end
    rdc("mask_reset", IDX_IRQ_MASK, 32'h0);
    rdc("unmapped", 4'hB, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    wr(IDX_IRQ_MASK, 32'h7);
    foreach (ops[k]) begin
      wr(IDX_COMMAND, {24'h0, ops[k]});
      apbc_host_i.wait_status(8'h00, st);
      flg("sleep_mode", 1'b1, 1'b1);
      rdc("power", IDX_POWER, 32'h1);
      rdc("irq_done", IDX_IRQ_STAT, 32'h1);
      flg("irq_high", 1'b0, 1'b1);
      wr(IDX_IRQ_STAT, 32'h1);
      flg("irq_clear", 1'b0, 1'b0);
    end
    wr(IDX_SECT_CNT, 32'h5A);
    wr(IDX_COMMAND, {24'h0, OP_WEAR});
    apbc_host_i.wait_status(8'h00, st);
    flg("wake", 1'b1, 1'b0);
    rdc("wear_cnt", IDX_SECT_CNT, {24'h0, WEAR_NOT_NEEDED});
    wr(IDX_IRQ_STAT, 32'h7);
    repeat (SLP + 5) @(posedge pclk);
    flg("auto_sleep", 1'b1, 1'b1);
    rdc("irq_auto", IDX_IRQ_STAT, 32'h4);
    wr(IDX_IRQ_MASK, 32'h3);
    flg("irq_masked", 1'b0, 1'b0);
    wr(IDX_IRQ_MASK, 32'h7);
    flg("irq_unmask", 1'b0, 1'b1);
    wr(IDX_IRQ_STAT, 32'h4);
    flg("irq_w1c", 1'b0, 1'b0);
    for (int e = 0; e < 2; e++) begin
      for (int i = 3; i <= 6; i++) begin
        tf[i] = 8'($urandom);
        wr(4'(i), {24'h0, tf[i]});
      end
      media_erased <= e[0];
      media_hot_count <= 24'($urandom);
      @(posedge pclk);
      blk = {};
      repeat (512) blk.push_back(8'h00);
      blk[0] = tf[5];
      blk[1] = tf[4];
      blk[2] = tf[6] & 8'h0F;
      blk[3] = tf[3];
      blk[4] = tf[5];
      blk[5] = tf[4];
      blk[6] = tf[3];
      blk[19] = e[0] ? 8'hFF : 8'h00;
      blk[24] = media_hot_count[23:16];
      blk[25] = media_hot_count[15:8];
      blk[26] = media_hot_count[7:0];
      wr(IDX_COMMAND, {24'h0, OP_TRANSLATE});
      apbc_host_i.wait_status(8'h08, st);
      rdc("irq_drq", IDX_IRQ_STAT, 32'h2);
      wr(IDX_IRQ_STAT, 32'h2);
      foreach (blk[j]) rdc("info_byte", IDX_DATA, {24'h0, blk[j]});
      rdc("xlat_idle", IDX_COMMAND, 32'h40);
      rdc("data_idle", IDX_DATA, 32'h0);
    end
    wr(IDX_COMMAND, {24'h0, OP_WRITE_BUF});
    apbc_host_i.wait_status(8'h08, st);
    rdc("wbuf_noirq", IDX_IRQ_STAT, 32'h0);
    rdc("wbuf_rd_zero", IDX_DATA, 32'h0);
    wr(IDX_SECT_NUM, 32'hA5);
    repeat (512) begin
      wq.push_back(8'($urandom));
      wr(IDX_DATA, {24'h0, wq[$]});
    end
    apbc_host_i.wait_status(8'h00, st);
    rdc("wbuf_done", IDX_IRQ_STAT, 32'h1);
    foreach (wq[j]) chk("wbuf_mem", {24'h0, wq[j]}, {24'h0, apbc_top_i.u_buf.mem_q[j]});
    rdc("tf_locked", IDX_SECT_NUM, {24'h0, tf[3]});
    // Unknown opcode aborts with the error bit and a done interrupt
    wr(IDX_IRQ_STAT, 32'h1);
    wr(IDX_COMMAND, 32'h0);
    apbc_host_i.wait_status(8'h00, st);
    rdc("abort_status", IDX_COMMAND, 32'h41);
    rdc("abort_done", IDX_IRQ_STAT, 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
